//--- rtl/wwdt_regs.svh
`ifndef WWDT_REGS_SVH
`define WWDT_REGS_SVH

// ==========
// Register indices (printed offsets; byte address is four times the index)
// ==========
`define WWDT_IDX_CONTROL_0      12'h80c
`define WWDT_IDX_CONTROL_1      12'h80d
`define WWDT_IDX_PRESCALE_LOW   12'h80e
`define WWDT_IDX_PRESCALE_HIGH  12'h80f
`define WWDT_IDX_WINDOW_TIMER   12'h810
`define WWDT_IDX_EVENT_STATUS   12'h811

// ==========
// Field positions
// ==========
`define WWDT_CTL0_SOFT_EN_BIT   0
`define WWDT_CTL0_PERIOD_LSB    1
`define WWDT_CTL1_WINDOW_LSB    0
`define WWDT_CTL1_CLOCK_LSB     4
`define WWDT_STAT_TIMEOUT_BIT   0
`define WWDT_STAT_POWERDOWN_BIT 1
`define WWDT_STAT_WDRESET_BIT   2
`define WWDT_STAT_VIOLATION_BIT 3

// ==========
// Reset values and codes
// ==========
`define WWDT_SOFT_EN_RESET      1'b0
`define WWDT_PERIOD_OPEN_CODE   5'h1f
`define WWDT_PERIOD_RESET_OPEN  5'h0b
`define WWDT_PERIOD_MAX_CODE    5'h12
`define WWDT_CLOCK_OPEN_CODE    3'h7
`define WWDT_CLOCK_RESET_OPEN   3'h0
`define WWDT_CLOCK_MEDIUM_CODE  3'h1
`define WWDT_WINDOW_OPEN_CODE   3'h7

`endif

//--- rtl/wwdt_pkg.sv
package wwdt_pkg;

    // ==========
    // Configuration word fields, captured at reset
    // ==========
    typedef struct packed {
        logic [1:0] config_operating_mode;
        logic [4:0] config_period_field;
        logic [2:0] config_clock_field;
        logic [2:0] config_window_field;
    } config_type;

    // Operating modes
    typedef enum logic [1:0] {
        MODE_OFF      = 2'h0,
        MODE_SOFTWARE = 2'h1,
        MODE_AWAKE    = 2'h2,
        MODE_ALWAYS   = 2'h3
    } mode_type;

    // Bus slave phases, Gray coded
    typedef enum logic [1:0] {
        BUS_IDLE = 2'h0,
        BUS_DATA = 2'h1
    } bus_state_type;

    // ==========
    // Whole state of the watchdog
    // ==========
    typedef struct packed {
        config_type    cfg;
        bus_state_type bus;
        logic          pend_write;
        logic [11:0]   pend_index;
        logic [31:0]   rdata;
        logic          ready;
        logic          soft_enable;
        logic [4:0]    period_select;
        logic [2:0]    clock_select;
        logic [2:0]    window_select;
        logic [17:0]   prescale_count;
        logic [4:0]    window_counter;
        logic          armed;
        logic          sleep_prev;
        logic          timeout_flag;
        logic          powerdown_flag;
        logic          watchdog_reset_flag;
        logic          window_violation_flag;
        logic          reset_req;
        logic          wake;
    } state_type;

endpackage

//--- rtl/windowed_watchdog_timer.sv
//
// Behaviour
// - Sleep entry clears prescaler and window counter
// - Counting resumes in Sleep if mode allows
// - Sleep exit clears; hold clear during start-up
// - Sleep time-out wakes, updates flags, no reset
// - Held clear: mode 00, 01 off, clear, oscfail
// - Mode 10 clears counter on Sleep entry
// - Oscillator divider change leaves counter alone
// - Period select doubles ratio from 1:32
// - Reserved period codes give minimum interval
// - Period select reset value and write lock
// - Soft enable acts only in mode 01
// - Clock select chooses low or medium oscillator
// - Clock select reset value and write lock
// - Window select sets open fraction of period
// - Window select reset value and write lock
// - Window open once counter reaches threshold
// - Timer register bit 2 shows armed
// - Prescaler count readable, reset to zero
// - Mode field selects when watchdog runs
// - Unarmed clear in windowed mode is violation
// - Clear while window closed resets device
// - Control register writes clear the counters
//
`timescale 1ns/1ns

`include "wwdt_regs.svh"

module windowed_watchdog_timer
(
    input  wire logic                 CLK_IN,
    input  wire logic                 SRST_IN,
    input  wire logic                 CE_IN,
    input  wire wwdt_pkg::config_type CFG_IN,
    input  wire logic                 LOW_FREQ_TICK_IN,
    input  wire logic                 MEDIUM_FREQ_TICK_IN,
    input  wire logic                 CLEAR_INSTRUCTION_IN,
    input  wire logic                 SLEEP_IN,
    input  wire logic                 STARTUP_TIMER_BUSY_IN,
    input  wire logic                 OSC_FAIL_IN,
    input  wire logic                 HSEL_IN,
    input  wire logic [31:0]          HADDR_IN,
    input  wire logic [1:0]           HTRANS_IN,
    input  wire logic                 HWRITE_IN,
    input  wire logic [2:0]           HSIZE_IN,
    input  wire logic [31:0]          HWDATA_IN,
    input  wire logic                 HREADY_IN,
    output logic [31:0]               HRDATA_OUT,
    output logic                      HREADYOUT_OUT,
    output logic                      HRESP_OUT,
    output logic                      DEVICE_RESET_OUT,
    output logic                      WAKE_OUT,
    output logic                      ARMED_OUT
);
    import wwdt_pkg::*;

    // ==========
    // Helper functions
    // ==========

    // Word index of a byte address; the index is compared against the map
    function automatic logic [11:0] addr_index(input logic [31:0] addr);
        addr_index = addr[13:2];
    endfunction

    // True when the upper address bits leave the register window or the address is not word aligned
    function automatic logic addr_outside(input logic [31:0] addr);
        addr_outside = (addr[31:14] != 18'h00000) || (addr[1:0] != 2'h0);
    endfunction

    // Reserved codes fall back to the shortest interval
    function automatic logic [4:0] period_shift(input logic [4:0] code);
        if (code > `WWDT_PERIOD_MAX_CODE)
            period_shift = 5'h00;
        else
            period_shift = code;
    endfunction

    // Reset state, loaded while the synchronous reset is held
    function automatic state_type reset_state(input config_type cfg);
        state_type r;
        r = '0;
        r.cfg = cfg;
        r.bus = BUS_IDLE;
        r.ready = 1'b1;
        r.soft_enable = `WWDT_SOFT_EN_RESET;
        // An open period field leaves the default interval writable
        if (cfg.config_period_field == `WWDT_PERIOD_OPEN_CODE)
            r.period_select = `WWDT_PERIOD_RESET_OPEN;
        else
            r.period_select = cfg.config_period_field;
        if (cfg.config_clock_field == `WWDT_CLOCK_OPEN_CODE)
            r.clock_select = `WWDT_CLOCK_RESET_OPEN;
        else
            r.clock_select = cfg.config_clock_field;
        r.window_select = cfg.config_window_field;
        r.prescale_count = 18'h00000;
        r.window_counter = 5'h00;
        // Status flags read as 1 until an event pulls them low
        r.timeout_flag = 1'b1;
        r.powerdown_flag = 1'b1;
        r.watchdog_reset_flag = 1'b1;
        r.window_violation_flag = 1'b1;
        reset_state = r;
    endfunction

    // ==========
    // State and combinational signals
    // ==========
    state_type   s;
    state_type   next_s;

    logic        sleep_entry;
    logic        sleep_exit;
    logic        active;
    logic        windowed;
    logic        window_open;
    logic        tick;
    logic        hold_clear;
    logic        clear_valid;
    logic        violation;
    logic        ctrl_write;
    logic        ctl0_read;
    logic        status_write;
    logic        period_end;
    logic        timeout;
    logic [4:0]  shift;
    logic [18:0] period_mask;
    logic [7:0]  wbyte;

    // ==========
    // Next-state logic
    // ==========
    always_comb
    begin
        next_s = s;
        next_s.reset_req = 1'b0;
        next_s.wake = 1'b0;
        next_s.sleep_prev = SLEEP_IN;
        ctrl_write = 1'b0;
        ctl0_read = 1'b0;
        status_write = 1'b0;
        wbyte = HWDATA_IN[7:0];

        // Bus slave: one wait state so that read data come from a register
        case (s.bus)
            BUS_IDLE:
            begin
                next_s.ready = 1'b1;
                if (HSEL_IN && HTRANS_IN[1] && HREADY_IN)
                begin
                    next_s.bus = BUS_DATA;
                    next_s.ready = 1'b0;
                    next_s.pend_write = HWRITE_IN;
                    // Unmapped addresses get an index no register owns
                    if (addr_outside(HADDR_IN))
                        next_s.pend_index = 12'h000;
                    else
                        next_s.pend_index = addr_index(HADDR_IN);
                end
            end
            BUS_DATA:
            begin
                next_s.bus = BUS_IDLE;
                next_s.ready = 1'b1;
                next_s.rdata = 32'h00000000;
                if (s.pend_write)
                begin
                    if (s.pend_index == `WWDT_IDX_CONTROL_0)
                    begin
                        ctrl_write = 1'b1;
                        next_s.soft_enable = wbyte[`WWDT_CTL0_SOFT_EN_BIT];
                        if (s.cfg.config_period_field == `WWDT_PERIOD_OPEN_CODE)
                            next_s.period_select = wbyte[`WWDT_CTL0_PERIOD_LSB +: 5];
                    end
                    else if (s.pend_index == `WWDT_IDX_CONTROL_1)
                    begin
                        ctrl_write = 1'b1;
                        if (s.cfg.config_clock_field == `WWDT_CLOCK_OPEN_CODE)
                            next_s.clock_select = wbyte[`WWDT_CTL1_CLOCK_LSB +: 3];
                        if (s.cfg.config_window_field == `WWDT_WINDOW_OPEN_CODE)
                            next_s.window_select = wbyte[`WWDT_CTL1_WINDOW_LSB +: 3];
                    end
                    else if (s.pend_index == `WWDT_IDX_EVENT_STATUS)
                    begin
                        status_write = 1'b1;
                    end
                end
                else
                begin
                    if (s.pend_index == `WWDT_IDX_CONTROL_0)
                    begin
                        ctl0_read = 1'b1;
                        next_s.rdata[7:0] = {2'h0, s.period_select, s.soft_enable};
                    end
                    else if (s.pend_index == `WWDT_IDX_CONTROL_1)
                    begin
                        next_s.rdata[7:0] = {1'b0, s.clock_select, 1'b0, s.window_select};
                    end
                    else if (s.pend_index == `WWDT_IDX_PRESCALE_LOW)
                    begin
                        next_s.rdata[7:0] = s.prescale_count[7:0];
                    end
                    else if (s.pend_index == `WWDT_IDX_PRESCALE_HIGH)
                    begin
                        next_s.rdata[7:0] = s.prescale_count[15:8];
                    end
                    else if (s.pend_index == `WWDT_IDX_WINDOW_TIMER)
                    begin
                        next_s.rdata[7:0] = {s.window_counter, s.armed,
                                             s.prescale_count[17:16]};
                    end
                    else if (s.pend_index == `WWDT_IDX_EVENT_STATUS)
                    begin
                        next_s.rdata[7:0] = {4'h0, s.window_violation_flag,
                                             s.watchdog_reset_flag, s.powerdown_flag,
                                             s.timeout_flag};
                    end
                end
            end
            default:
            begin
                next_s.bus = BUS_IDLE;
                next_s.ready = 1'b1;
            end
        endcase

        // Sleep transitions seen on the core's level
        sleep_entry = SLEEP_IN && !s.sleep_prev;
        sleep_exit = !SLEEP_IN && s.sleep_prev;

        // Run conditions per mode; the soft enable matters only in mode 01
        case (mode_type'(s.cfg.config_operating_mode))
            MODE_ALWAYS:   active = 1'b1;
            MODE_AWAKE:    active = !SLEEP_IN;
            MODE_SOFTWARE: active = s.soft_enable;
            default:       active = 1'b0;
        endcase

        // Window open once the counter reaches the code's threshold
        windowed = (s.window_select != `WWDT_WINDOW_OPEN_CODE);
        window_open = (s.window_counter >= {~s.window_select, 2'h0});

        // A clear only counts while the watchdog runs; in windowed mode it
        // must be armed and inside the window, otherwise, while awake, it is a violation
        clear_valid = CLEAR_INSTRUCTION_IN && active &&
                      (!windowed || (s.armed && window_open));
        violation = CLEAR_INSTRUCTION_IN && active && !clear_valid && !SLEEP_IN;

        // Selected oscillator tick; reserved codes stay on the low one. The
        // core's oscillator divider has no input here, so it cannot disturb
        // the count.
        if (s.clock_select == `WWDT_CLOCK_MEDIUM_CODE)
            tick = MEDIUM_FREQ_TICK_IN;
        else
            tick = LOW_FREQ_TICK_IN;

        // Every clearing cause in one term
        hold_clear = !active || CLEAR_INSTRUCTION_IN || OSC_FAIL_IN
                     || sleep_entry
                     || sleep_exit || STARTUP_TIMER_BUSY_IN
                     || ctrl_write;

        // The window counter steps once per thirty-second of the period
        shift = period_shift(s.period_select);
        period_mask = (19'h00001 << shift) - 19'h00001;
        period_end = tick && (s.prescale_count == period_mask[17:0]);
        timeout = period_end && (s.window_counter == 5'h1f);

        if (hold_clear)
        begin
            next_s.prescale_count = 18'h00000;
            next_s.window_counter = 5'h00;
        end
        else if (period_end)
        begin
            // Counting carries on after the entry clear when still active
            next_s.prescale_count = 18'h00000;
            next_s.window_counter = s.window_counter + 5'h01;
        end
        else if (tick)
        begin
            next_s.prescale_count = s.prescale_count + 18'h00001;
        end

        // Arming: a read of control 0 arms, a good clear disarms
        if (ctl0_read)
            next_s.armed = 1'b1;
        else if (clear_valid)
            next_s.armed = 1'b0;

        // Status flags: software writes a 1 to restore a flag, but a
        // hardware event in the same cycle wins
        if (status_write)
        begin
            if (wbyte[`WWDT_STAT_TIMEOUT_BIT])
                next_s.timeout_flag = 1'b1;
            if (wbyte[`WWDT_STAT_POWERDOWN_BIT])
                next_s.powerdown_flag = 1'b1;
            if (wbyte[`WWDT_STAT_WDRESET_BIT])
                next_s.watchdog_reset_flag = 1'b1;
            if (wbyte[`WWDT_STAT_VIOLATION_BIT])
                next_s.window_violation_flag = 1'b1;
        end

        // Time-out: reset while awake, wake-up while asleep
        if (timeout && !hold_clear)
        begin
            next_s.timeout_flag = 1'b0;
            next_s.watchdog_reset_flag = 1'b0;
            if (SLEEP_IN)
            begin
                next_s.wake = 1'b1;
                next_s.powerdown_flag = 1'b0;
            end
            else
            begin
                next_s.reset_req = 1'b1;
            end
        end

        // A violation resets the device like a time-out does
        if (violation)
        begin
            next_s.reset_req = 1'b1;
            next_s.window_violation_flag = 1'b0;
        end
    end

    // ==========
    // State register; the clock enable freezes everything but the synchronous reset
    // ==========
    always_ff @(posedge CLK_IN)
    begin
        if (SRST_IN)
            s <= reset_state(CFG_IN);
        else if (CE_IN)
            s <= next_s;
    end

    // ==========
    // Outputs, all but HRESP_OUT straight from the state register
    // ==========
    assign HRDATA_OUT = s.rdata;
    assign HREADYOUT_OUT = s.ready;
    assign HRESP_OUT = 1'b0;              // Always OKAY, never an error
    assign DEVICE_RESET_OUT = s.reset_req;
    assign WAKE_OUT = s.wake;
    assign ARMED_OUT = s.armed;           // Mirrors timer register bit 2

endmodule // windowed_watchdog_timer

//--- dv/wwdt_chk.sv
`timescale 1ns/1ns

// ==========
// Port checks of the watchdog
// ==========
module wwdt_chk
(
    input wire logic                 CLK_IN,
    input wire logic                 SRST_IN,
    input wire logic                 CE_IN,
    input wire wwdt_pkg::config_type CFG_IN,
    input wire logic                 CLEAR_INSTRUCTION_IN,
    input wire logic                 SLEEP_IN,
    input wire logic                 STARTUP_TIMER_BUSY_IN,
    input wire logic                 OSC_FAIL_IN,
    input wire logic                 HSEL_IN,
    input wire logic [31:0]          HADDR_IN,
    input wire logic [1:0]           HTRANS_IN,
    input wire logic                 HWRITE_IN,
    input wire logic                 HREADY_IN,
    input wire logic                 HREADYOUT_OUT,
    input wire logic                 DEVICE_RESET_OUT,
    input wire logic                 WAKE_OUT,
    input wire logic                 ARMED_OUT
);
    import wwdt_pkg::*;

    logic [1:0] mode_q;
    logic       taken;
    logic       rd_ctl0;
    logic       wr_ctl;

    // Mode is latched like the design does, since the input may move later
    always_ff @(posedge CLK_IN)
        if (SRST_IN)
            mode_q <= CFG_IN.config_operating_mode;

    // Address phases accepted by the slave
    assign taken   = HSEL_IN && HTRANS_IN[1] && HREADY_IN && CE_IN && HREADYOUT_OUT;
    assign rd_ctl0 = taken && !HWRITE_IN && (HADDR_IN == 32'h2030);
    assign wr_ctl  = taken && HWRITE_IN && (HADDR_IN == 32'h2030 || HADDR_IN == 32'h2034);

    default clocking cb @(posedge CLK_IN); endclocking
    default disable iff (SRST_IN);

    // ==========
    // Assertions
    // ==========
    AST_NO_RESET_ASLEEP: assert property (
        SLEEP_IN && $past(SLEEP_IN) && $past(SLEEP_IN, 2) |-> !DEVICE_RESET_OUT)
        else $error("device reset raised while asleep");
    AST_NO_WAKE_AWAKE: assert property (
        !SLEEP_IN && !$past(SLEEP_IN) && !$past(SLEEP_IN, 2) |-> !WAKE_OUT)
        else $error("wake raised while awake");
    AST_MODE_OFF_SILENT: assert property (
        mode_q == MODE_OFF |-> !DEVICE_RESET_OUT && !WAKE_OUT)
        else $error("event seen with watchdog off");
    AST_PULSE_SINGLE: assert property (
        (DEVICE_RESET_OUT || WAKE_OUT) |=> !DEVICE_RESET_OUT && !WAKE_OUT)
        else $error("event pulse longer than one cycle");
    AST_OSC_FAIL_HOLD: assert property (
        $past(OSC_FAIL_IN) && $past(OSC_FAIL_IN, 2) && !$past(CLEAR_INSTRUCTION_IN)
        && !$past(CLEAR_INSTRUCTION_IN, 2) |-> !DEVICE_RESET_OUT && !WAKE_OUT)
        else $error("time-out during oscillator failure");
    AST_STARTUP_HOLD: assert property (
        $past(STARTUP_TIMER_BUSY_IN) && $past(STARTUP_TIMER_BUSY_IN, 2)
        && !$past(CLEAR_INSTRUCTION_IN) |-> !DEVICE_RESET_OUT && !WAKE_OUT)
        else $error("time-out during start-up hold");
    AST_ARM_ON_READ: assert property (
        rd_ctl0 |=> !HREADYOUT_OUT ##1 (HREADYOUT_OUT && ARMED_OUT))
        else $error("control 0 read did not arm");
    AST_ARM_AT_READ_END: assert property (
        $rose(ARMED_OUT) |-> !$past(HREADYOUT_OUT))
        else $error("armed rose outside a bus transfer");
    AST_CLEAR_DISARMS: assert property (
        CLEAR_INSTRUCTION_IN && ARMED_OUT && !HSEL_IN && mode_q == MODE_ALWAYS
        |-> ##[1:2] (!ARMED_OUT || DEVICE_RESET_OUT))
        else $error("armed kept after clear");
    AST_WRITE_CLEARS: assert property (
        wr_ctl |-> ##3 (!DEVICE_RESET_OUT && !WAKE_OUT) [*8])
        else $error("event soon after control write");
endmodule // wwdt_chk

bind windowed_watchdog_timer wwdt_chk i_chk (
    .CLK_IN(CLK_IN), .SRST_IN(SRST_IN), .CE_IN(CE_IN), .CFG_IN(CFG_IN),
    .CLEAR_INSTRUCTION_IN(CLEAR_INSTRUCTION_IN), .SLEEP_IN(SLEEP_IN),
    .STARTUP_TIMER_BUSY_IN(STARTUP_TIMER_BUSY_IN), .OSC_FAIL_IN(OSC_FAIL_IN),
    .HSEL_IN(HSEL_IN), .HADDR_IN(HADDR_IN), .HTRANS_IN(HTRANS_IN), .HWRITE_IN(HWRITE_IN),
    .HREADY_IN(HREADY_IN), .HREADYOUT_OUT(HREADYOUT_OUT),
    .DEVICE_RESET_OUT(DEVICE_RESET_OUT), .WAKE_OUT(WAKE_OUT), .ARMED_OUT(ARMED_OUT));

//--- dv/core_model.sv
`timescale 1ns/1ns

// ==========
// Processor core: bus master, clear instructions, sleep reporting
// ==========
module core_model
(
    input  wire logic        clk_in,
    input  wire logic [31:0] hrdata_in,
    input  wire logic        hready_in,
    output logic             hsel_out,
    output logic [31:0]      haddr_out,
    output logic [1:0]       htrans_out,
    output logic             hwrite_out,
    output logic [2:0]       hsize_out,
    output logic [31:0]      hwdata_out,
    output logic             clear_out,
    output logic             sleep_out
);
    // Idle at time zero; unused data lines never show stale values
    initial
    begin
        {hsel_out, htrans_out, hwrite_out, clear_out, sleep_out, haddr_out} = '0;
        hsize_out  = 3'h2;
        hwdata_out = 32'h5a5a5a5a;
    end

    // Single word transfer; each phase is held until ready is sampled high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic ok);
        int n;
        n = 0;
        @(posedge clk_in);
        hsel_out   <= 1'b1;
        htrans_out <= 2'h2;
        haddr_out  <= a;
        hwrite_out <= w;
        do @(posedge clk_in); while (!hready_in && ++n < 64);
        hsel_out   <= 1'b0;
        htrans_out <= 2'h0;
        haddr_out  <= ~a;
        hwdata_out <= w ? d : ~hwdata_out;
        do @(posedge clk_in); while (!hready_in && ++n < 128);
        r  = hrdata_in;
        ok = (n < 128);
        hwdata_out <= ~hwdata_out; // Released data toggles
    endtask

    // One-cycle clear instruction
    task automatic clr();
        @(posedge clk_in);
        clear_out <= 1'b1;
        @(posedge clk_in);
        clear_out <= 1'b0;
    endtask

    // Sleep entry or exit
    task automatic slp(input logic s);
        @(posedge clk_in);
        sleep_out <= s;
    endtask
endmodule // core_model

//--- dv/windowed_watchdog_timer_tb.sv
`timescale 1ns/1ns

`include "wwdt_regs.svh"

module windowed_watchdog_timer_tb;
    import wwdt_pkg::*;

    localparam logic [31:0] A_C0 = {18'h0, `WWDT_IDX_CONTROL_0, 2'b00};
    localparam logic [31:0] A_C1 = {18'h0, `WWDT_IDX_CONTROL_1, 2'b00};
    localparam logic [31:0] A_PL = {18'h0, `WWDT_IDX_PRESCALE_LOW, 2'b00};
    localparam logic [31:0] A_PH = {18'h0, `WWDT_IDX_PRESCALE_HIGH, 2'b00};
    localparam logic [31:0] A_TM = {18'h0, `WWDT_IDX_WINDOW_TIMER, 2'b00};
    localparam logic [31:0] A_ST = {18'h0, `WWDT_IDX_EVENT_STATUS, 2'b00};

    logic        clk = 0, srst = 1, ce = 1, lft = 0, mft = 0, stb = 0, ofl = 0;
    config_type  cfg = '{2'h3, 5'h1f, 3'h7, 3'h7};
    logic [31:0] hrdata, haddr, hwdata, r;
    logic        hready, hresp, dres, wake, armed, hsel, hwrite, clr, slp;
    logic [1:0]  htrans;
    logic [2:0]  hsize;
    int          n_errors = 0, checks_done = 0, n;

    always #5 clk = ~clk;

    windowed_watchdog_timer i_dut (.CLK_IN(clk), .SRST_IN(srst), .CE_IN(ce), .CFG_IN(cfg),
        .LOW_FREQ_TICK_IN(lft), .MEDIUM_FREQ_TICK_IN(mft), .CLEAR_INSTRUCTION_IN(clr),
        .SLEEP_IN(slp), .STARTUP_TIMER_BUSY_IN(stb), .OSC_FAIL_IN(ofl), .HSEL_IN(hsel),
        .HADDR_IN(haddr), .HTRANS_IN(htrans), .HWRITE_IN(hwrite), .HSIZE_IN(hsize),
        .HWDATA_IN(hwdata), .HREADY_IN(hready), .HRDATA_OUT(hrdata), .HREADYOUT_OUT(hready),
        .HRESP_OUT(hresp), .DEVICE_RESET_OUT(dres), .WAKE_OUT(wake), .ARMED_OUT(armed));
    core_model i_core (.clk_in(clk), .hrdata_in(hrdata), .hready_in(hready), .hsel_out(hsel),
        .haddr_out(haddr), .htrans_out(htrans), .hwrite_out(hwrite), .hsize_out(hsize),
        .hwdata_out(hwdata), .clear_out(clr), .sleep_out(slp));

    // ==========
    // Shared tasks
    // ==========
    task automatic stop_test();
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e)
        begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // A hung bus ends the run at once
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        logic ok;
        i_core.xfer(w, a, d, r, ok);
        chk("bus answer", 1'b1, ok && hresp === 1'b0);
        if (!ok)
            stop_test();
    endtask

    task automatic rdc(input string nm, input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        chk(nm, e, r);
    endtask

    // Counts edges until reset (w=0) or wake (w=1); n equals b if none came
    task automatic wait_ev(input logic w, input int b);
        n = 0;
        while (n < b && (w ? wake : dres) !== 1'b1)
        begin
            @(posedge clk);
            n++;
        end
    endtask

    task automatic do_reset(input config_type c);
        srst <= 1'b1;
        cfg  <= c;
        repeat (2) @(posedge clk);
        srst <= 1'b0;
    endtask

    // ==========
    // Scenarios
    // ==========
    task automatic t_regs();
        rdc("timer", A_TM, 32'h0);
        rdc("prescale low", A_PL, 32'h0);
        rdc("prescale high", A_PH, 32'h0);
        rdc("control 0", A_C0, 32'h16);
        rdc("control 1", A_C1, 32'h07);
        rdc("unmapped", 32'h3000, 32'h0);
        xfer(1'b1, A_C0, 32'h3e);
        rdc("control 0 rw", A_C0, 32'h3e);
        xfer(1'b1, A_C1, 32'hff);
        rdc("control 1 rw", A_C1, 32'h77);
    endtask

    // Medium oscillator only; reserved codes must time out like code 0
    task automatic t_period();
        int code [4] = '{0, 1, 19, 31};
        int exp  [4] = '{32, 64, 32, 32};
        mft <= 1'b1;
        xfer(1'b1, A_C1, 32'h17);
        foreach (code[i])
        begin
            xfer(1'b1, A_C0, code[i] << 1);
            if (i == 0)
            begin
                ofl <= 1'b1;
                wait_ev(1'b0, 80);
                chk("held by osc fail", 80, n);
                ofl <= 1'b0;
            end
            wait_ev(1'b0, 100);
            chk("period ok", 1'b1, n >= exp[i] - 2 && n <= exp[i] + 3);
        end
    endtask

    task automatic t_sleep();
        xfer(1'b1, A_ST, 32'h0f);
        i_core.slp(1'b1);
        wait_ev(1'b1, 60);
        chk("wake in sleep", 1'b1, n < 60);
        stb <= 1'b1;
        i_core.slp(1'b0);
        wait_ev(1'b0, 60);
        chk("held by start-up", 60, n);
        rdc("status", A_ST, 32'h08);
        stb <= 1'b0;
    endtask

    // Polls until the 12.5 percent window opens
    task automatic wopen();
        int k;
        k = 0;
        do xfer(1'b0, A_TM, 32'h0); while (r[7:3] < 5'h1c && ++k < 400);
        chk("window reached", 1'b1, k < 400);
        if (k >= 400)
            stop_test();
    endtask

    // Starts from reset: earlier control 0 reads leave the watchdog armed
    task automatic t_window();
        do_reset(cfg);
        xfer(1'b1, A_C1, 32'h10);
        xfer(1'b1, A_C0, 32'h0a);
        wopen();
        i_core.clr();
        wait_ev(1'b0, 6);
        chk("unarmed clear", 1'b1, n < 6);
        xfer(1'b0, A_C0, 32'h0);
        xfer(1'b0, A_TM, 32'h0);
        chk("armed bit", 1'b1, r[2]);
        i_core.clr();
        wait_ev(1'b0, 6);
        chk("closed clear", 1'b1, n < 6);
        wopen();
        xfer(1'b0, A_C0, 32'h0);
        i_core.clr();
        wait_ev(1'b0, 20);
        chk("armed clear", 20, n);
        chk("armed out", 1'b0, armed);
    endtask

    task automatic t_modes();
        lft <= 1'b1;
        mft <= 1'b0;
        do_reset('{2'h1, 5'h00, 3'h0, 3'h7});
        wait_ev(1'b0, 50);
        chk("soft off", 50, n);
        rdc("soft off count", A_PL, 32'h0);
        xfer(1'b1, A_C0, 32'h3f);
        rdc("period locked", A_C0, 32'h01);
        wait_ev(1'b0, 50);
        chk("soft on", 1'b1, n < 50);
        do_reset('{2'h2, 5'h00, 3'h0, 3'h7});
        i_core.slp(1'b1);
        wait_ev(1'b1, 50);
        chk("awake mode asleep", 50, n);
        i_core.slp(1'b0);
        wait_ev(1'b0, 50);
        chk("awake mode runs", 1'b1, n < 50);
        do_reset('{2'h0, 5'h00, 3'h0, 3'h7});
        wait_ev(1'b0, 60);
        chk("mode off", 60, n);
    endtask

    // Main sequence
    initial
    begin
        do_reset(cfg);
        t_regs();
        t_period();
        t_sleep();
        t_window();
        t_modes();
        stop_test();
    end
endmodule // windowed_watchdog_timer_tb
